// ### hw/dsw_defs.vh
// constants shared by the serial write port design
`ifndef DSW_DEFS_VH
`define DSW_DEFS_VH
`define DSW_WORD_BITS   16
`define DSW_CNT_BITS    5
`define DSW_MODE_HI_POS 15
`define DSW_MODE_LO_POS 14
`define DSW_DATA_BITS   14
`define DSW_MODE_NORMAL 2'h0
`define DSW_MODE_PD_1K  2'h1
`define DSW_MODE_PD_100K 2'h2
`define DSW_MODE_PD_TRI 2'h3
`define DSW_WORD_RESET  16'h0000
`define DSW_LAST_CNT    5'h0f
`endif

// ### hw/dsw_sync3.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module dsw_sync3 (
  input  wire clk,    // sampling clock
  input  wire rst_n,  // synchronous-domain reset, active low
  input  wire din,    // asynchronous pin level
  output reg  dout    // filtered level
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a change counts only once stages two and three agree
      if (s2_q == s3_q)
        dout <= s3_q;
    end
  end
endmodule // dsw_sync3

// ### hw/dsw_port.v
// serial write port: frame-select, serial clock and data into converter register
`timescale 1ns/10ps
`include "dsw_defs.vh"
module dsw_port (
  input  wire        clk,          // 100 MHz system clock
  input  wire        resetn,       // asynchronous reset, active low
  input  wire        sync_n,       // frame select pin, active low
  input  wire        sclk,         // serial clock pin
  input  wire        din,          // serial data pin
  output reg  [13:0] dac_code,     // converter register
  output reg  [1:0]  op_mode,      // operating mode bits
  output reg         out_enable,   // amplifier drives the output
  output reg         pd_1k,        // power-down with 1k to ground
  output reg         pd_100k,      // power-down with 100k to ground
  output reg         pd_tri,       // power-down with open output
  output reg         load_pulse    // one-cycle pulse when a word is applied
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_SHIFT = 3'b010;
  localparam ST_DONE  = 3'b100;

  // reset release chain
  reg         rst_s1_q;
  reg         rst_n_q;

  // filtered pin levels
  wire        sync_f;
  wire        sclk_f;
  wire        din_f;

  // edge history
  reg         sclk_prev_q;
  reg         sync_prev_q;
  wire        fall_edge;
  wire        sync_fall;
  wire        sync_high;

  // frame state, registered and next
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [15:0] shift_q;
  reg  [15:0] shift_d;
  reg  [4:0]  cnt_q;
  reg  [4:0]  cnt_d;
  wire        last_bit;
  wire [15:0] word_next;

  // next values of the output registers
  reg  [13:0] dac_code_d;
  reg  [1:0]  op_mode_d;
  reg         load_pulse_d;

  // appends one serial bit below those already taken, so the first bit ends on top
  function [15:0] shift_in;
    input [15:0] w;
    input        b;
    begin
      shift_in = {w[14:0], b};
    end
  endfunction

  function [1:0] mode_of;
    input [15:0] w;
    begin
      mode_of = {w[`DSW_MODE_HI_POS], w[`DSW_MODE_LO_POS]};
    end
  endfunction

  function [13:0] data_of;
    input [15:0] w;
    begin
      data_of = w[`DSW_DATA_BITS-1:0];
    end
  endfunction

  function is_mode;
    input [1:0] m;
    input [1:0] code;
    begin
      is_mode = (m == code);
    end
  endfunction

  // reset is taken at once but let go only after two clean clock edges
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // frame select idles high; its filter starts low, but a frame needs a fall from high
  dsw_sync3 u_sync_cs (
    .clk   (clk),
    .rst_n (rst_n_q),
    .din   (sync_n),
    .dout  (sync_f)
  );

  // serial clock idles low, matching the filter's reset level, so no false edge
  dsw_sync3 u_sync_ck (
    .clk   (clk),
    .rst_n (rst_n_q),
    .din   (sclk),
    .dout  (sclk_f)
  );

  // data passes the same three stages as the clock, so it stays aligned with the edge
  dsw_sync3 u_sync_di (
    .clk   (clk),
    .rst_n (rst_n_q),
    .din   (din),
    .dout  (din_f)
  );

  assign fall_edge = sclk_prev_q & ~sclk_f;
  assign sync_fall = sync_prev_q & ~sync_f;
  assign sync_high = sync_f;
  assign last_bit  = (cnt_q == `DSW_LAST_CNT);
  assign word_next = shift_in(shift_q, din_f);

  always @* begin
    state_d      = state_q;
    shift_d      = shift_q;
    cnt_d        = cnt_q;
    dac_code_d   = dac_code;
    op_mode_d    = op_mode;
    load_pulse_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        // a select idled low never restarts; it must go high and fall again
        if (sync_fall) begin
          state_d = ST_SHIFT;
          cnt_d   = 5'h00;
          shift_d = `DSW_WORD_RESET;
        end
      end
      ST_SHIFT: begin
        if (sync_high) begin
          // partial word is dropped; outputs keep their stored values
          state_d = ST_IDLE;
          cnt_d   = 5'h00;
          shift_d = `DSW_WORD_RESET;
        end else if (fall_edge) begin
          shift_d = word_next;
          if (last_bit) begin
            state_d      = ST_DONE;
            dac_code_d   = data_of(word_next);
            op_mode_d    = mode_of(word_next);
            load_pulse_d = 1'b1;
          end else begin
            cnt_d = cnt_q + 5'h01;
          end
        end
      end
      ST_DONE: begin
        // further edges are ignored until frame select goes high
        if (sync_high) begin
          state_d = ST_IDLE;
          cnt_d   = 5'h00;
          shift_d = `DSW_WORD_RESET;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d   = 5'h00;
        shift_d = `DSW_WORD_RESET;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sclk_prev_q <= 1'b0;
      sync_prev_q <= 1'b0;
      state_q     <= ST_IDLE;
      shift_q     <= `DSW_WORD_RESET;
      cnt_q       <= 5'h00;
      dac_code    <= 14'h0000;
      op_mode     <= `DSW_MODE_NORMAL;
      load_pulse  <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_f;
      sync_prev_q <= sync_f;
      state_q     <= state_d;
      shift_q     <= shift_d;
      cnt_q       <= cnt_d;
      dac_code    <= dac_code_d;
      op_mode     <= op_mode_d;
      load_pulse  <= load_pulse_d;
    end
  end

  // power-down only steers the output stage; dac_code is left as stored
  always @* begin
    out_enable = is_mode(op_mode, `DSW_MODE_NORMAL);
    pd_1k      = is_mode(op_mode, `DSW_MODE_PD_1K);
    pd_100k    = is_mode(op_mode, `DSW_MODE_PD_100K);
    pd_tri     = is_mode(op_mode, `DSW_MODE_PD_TRI);
  end
endmodule // dsw_port

// ### tb/dsw_port_asserts.sv
// port checker
`timescale 1ns/10ps
module dsw_port_asserts (
  input wire logic        clk,        // clock
  input wire logic        resetn,     // reset
  input wire logic        sync_n,     // frame
  input wire logic        sclk,       // sclk
  input wire logic [13:0] dac_code,   // code
  input wire logic [1:0]  op_mode,    // mode
  input wire logic        out_enable, // on
  input wire logic        pd_1k,      // 1k
  input wire logic        pd_100k,    // 100k
  input wire logic        pd_tri,     // open
  input wire logic        load_pulse  // load
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_ON: assert property (out_enable == (op_mode == 2'h0)) else $error("on");
  AST_1K: assert property (pd_1k == (op_mode == 2'h1)) else $error("1k");
  AST_100K: assert property (pd_100k == (op_mode == 2'h2)) else $error("100k");
  AST_TRI: assert property (pd_tri == (op_mode == 2'h3)) else $error("tri");
  AST_HOLD: assert property ($changed({op_mode, dac_code}) |-> load_pulse) else $error("hold");
  AST_ONE: assert property (load_pulse |=> !load_pulse [*8]) else $error("pulse");
  AST_IDLE: assert property (sync_n [*8] |=> !load_pulse) else $error("idle");
  AST_STILL: assert property ($stable(sclk) [*8] |=> !load_pulse) else $error("still");
  AST_RST: assert property (disable iff (1'b0) !resetn [*2] |-> !dac_code && !load_pulse)
    else $error("rst");
  cover property (load_pulse && op_mode == 2'h3);
  cover property (load_pulse && !op_mode);
  cover property ($rose(sync_n) ##1 !load_pulse [*8]);
endmodule // dsw_port_asserts
bind dsw_port dsw_port_asserts dsw_port_asserts_i (.*);

// ### tb/dsw_host.sv
// host model sending frames
`timescale 1ns/10ps
module dsw_host (
  input  logic clk,    // bench clock
  output logic sync_n, // frame
  output logic sclk,   // clock
  output logic din     // data
);
  initial {sync_n, sclk, din} = 3'b100;
  // sclk stands still outside frames; eight clocks a half period make 80 ns, a 160 ns sclk period
  task automatic frame(input logic [15:0] w, input int n);
    sync_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b1;
      din  <= w[15-i];
      repeat (8) @(posedge clk);
      sclk <= 1'b0;
      repeat (8) @(posedge clk);
    end
    din    <= ~din;
    sync_n <= 1'b1;
    repeat (40) @(posedge clk);
  endtask
endmodule // dsw_host

// ### tb/tb.sv
// port testbench
`timescale 1ns/10ps
module tb;
  logic clk = 0, resetn = 0;
  wire sync_n, sclk, din, out_enable, pd_1k, pd_100k, pd_tri, load_pulse;
  wire [13:0] dac_code;
  wire [1:0] op_mode;
  logic [15:0] exp_q[$], w;
  int error_cnt, n_compared;
  always #5 clk = ~clk;
  dsw_host dsw_host_i (.*);
  dsw_port dsw_port_i (.*);
  task check(input string nm, input logic [15:0] e, s);
    n_compared++;
    if (e !== s) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // an unexpected load meets an unknown note
  always @(posedge clk) if (load_pulse === 1'b1)
    check("word", exp_q.size() ? exp_q.pop_front() : 16'hxxxx, {op_mode, dac_code});
  initial begin
    void'($urandom(32'h48e3b42f));
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (10) @(posedge clk);
    check("reset", 16'h0, {op_mode, dac_code});
    for (int m = 0; m < 4; m++) begin
      w = {m[1:0], 14'($urandom)};
      exp_q.push_back(w);
      dsw_host_i.frame(w, 16);
      check("decode", {12'h000, 4'h8 >> m}, {12'h000, out_enable, pd_1k, pd_100k, pd_tri});
      dsw_host_i.frame(~w, $urandom_range(1, 15));
      $display("mode %0d done", m);
    end
    check("final", w, {op_mode, dac_code});
    finish_test;
  end
  initial begin
    #60000;
    error_cnt++;
    finish_test;
  end
endmodule // tb
